// ===== bst_pkg.sv
// Constants and types shared by the boundary-scan test port
package bst_pkg;

  // ****************************************************************
  // Instruction register
  // ****************************************************************
  localparam int IR_LEN = 4;
  localparam logic [3:0] OP_EXTEST = 4'h0;
  localparam logic [3:0] OP_SAMPLE = 4'h1;
  localparam logic [3:0] OP_IDCODE = 4'h2;
  localparam logic [3:0] OP_CLAMP = 4'h3;
  localparam logic [3:0] OP_HIGHZ = 4'h4;
  localparam logic [3:0] OP_BYPASS = 4'hF;
  // Low bits 01 are the fixed capture pattern of the instruction path
  localparam logic [3:0] IR_CAPTURE = 4'h1;

  // ****************************************************************
  // Identification word and data paths
  // ****************************************************************
  localparam int ID_LEN = 32;
  // Arbitrary identity values
  localparam logic [3:0] ID_VERSION = 4'h1;
  localparam logic [15:0] ID_PART = 16'h0A5C;
  localparam logic [10:0] ID_MFR = 11'h07E;
  localparam logic ID_FIXED = 1'h1;
  localparam logic PASS_CAPTURE = 1'h0;
  localparam int CELLS_PER_PIN = 2;
  localparam int FIFO_DEPTH = 8;
  localparam int TMS_RESET_EDGES = 5;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [3:0] {
    ST_E2DR = 4'h0, ST_E1DR = 4'h1, ST_SHDR = 4'h2, ST_PDR = 4'h3,
    ST_SIR = 4'h4, ST_UDR = 4'h5, ST_CDR = 4'h6, ST_SDR = 4'h7,
    ST_E2IR = 4'h8, ST_E1IR = 4'h9, ST_SHIR = 4'hA, ST_PIR = 4'hB,
    ST_RTI = 4'hC, ST_UIR = 4'hD, ST_CIR = 4'hE, ST_TLR = 4'hF
  } bst_state_t;

  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } bst_pins_t;

endpackage : bst_pkg

// ===== bst_fifo.sv
// Small FIFO with a registered read stage
`timescale 1ns/1ps
module bst_fifo #(
  parameter int W = 1,
  parameter int DEPTH = 8
) (
  input wire logic clk, // System clock
  input wire logic rst, // Synchronous reset
  input wire logic clk_en, // Freezes all state when low
  input wire logic in_valid, // Write request
  output logic in_ready, // Space available
  input wire logic [W-1:0] in_data, // Write data
  output logic out_valid, // Read data present
  input wire logic out_ready, // Consumer takes word
  output logic [W-1:0] out_data // Registered read data
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q, rp_q;
  logic [AW:0] cnt_q;
  logic ov_q;
  logic [W-1:0] od_q;

  // Handshake decode
  wire wr = in_valid && in_ready;
  wire load = (cnt_q != '0) && (!ov_q || out_ready);
  wire drop = ov_q && out_ready && !load;
  assign in_ready = (cnt_q != FULL);
  assign out_valid = ov_q;
  assign out_data = od_q;

  // Storage array, no reset needed on data
  always_ff @(posedge clk) begin
    if (clk_en && wr) begin
      mem_q[wp_q] <= in_data;
    end
  end

  // Pointers, count and output stage
  always_ff @(posedge clk) begin
    if (rst) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
      ov_q <= 1'h0;
      od_q <= '0;
    end else if (clk_en) begin
      if (wr) wp_q <= wp_q + AW'(1);
      if (load) rp_q <= rp_q + AW'(1);
      if (load) od_q <= mem_q[rp_q];
      cnt_q <= cnt_q + (AW+1)'(wr) - (AW+1)'(load);
      if (load) ov_q <= 1'h1;
      else if (drop) ov_q <= 1'h0;
    end
  end

endmodule : bst_fifo

// ===== bst_tap.sv
// Boundary-scan test access port with chain, identity and bypass paths
`timescale 1ns/1ps
module bst_tap #(
  parameter int N_PINS = 16,
  parameter int FIFO_DEPTH = bst_pkg::FIFO_DEPTH
) (
  input wire logic clk, // 250 MHz system clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic clk_en, // Freezes all state when low
  input wire bst_pkg::bst_pins_t jtag_i, // Test clock, mode, data-in
  output logic tdo, // Test data out
  output logic tdo_oe, // High while data-out is driven
  input wire logic [N_PINS-1:0] core_out, // Core value for each pin
  input wire logic [N_PINS-1:0] core_oe, // Core enable for each pin
  input wire logic [N_PINS-1:0] pad_in, // Level seen at each pin
  output logic [N_PINS-1:0] pad_out, // Value driven to each pin
  output logic [N_PINS-1:0] pad_oe // Enable for each pin
);
  localparam int CL = bst_pkg::CELLS_PER_PIN * N_PINS;
  localparam int IL = bst_pkg::IR_LEN;
  localparam logic [2:0] RUN_MAX = 3'(bst_pkg::TMS_RESET_EDGES);

  // ****************************************************************
  // Pin synchronisers and test clock edges
  // ****************************************************************
  bst_pkg::bst_pins_t pin_s1_q, pin_s2_q;
  logic tck_s3_q;
  logic [N_PINS-1:0] pad_s1_q, pad_s2_q;

  // Two flops on every pin from outside the clock domain
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      tck_s3_q <= 1'h0;
      pad_s1_q <= '0;
      pad_s2_q <= '0;
    end else if (clk_en) begin
      pin_s1_q <= jtag_i;
      pin_s2_q <= pin_s1_q;
      tck_s3_q <= pin_s2_q.tck;
      pad_s1_q <= pad_in;
      pad_s2_q <= pad_s1_q;
    end
  end

  // Edge detect looks only at the second and third stages
  wire rise_ev = pin_s2_q.tck && !tck_s3_q;
  wire fall_ev = !pin_s2_q.tck && tck_s3_q;
  wire tms = pin_s2_q.tms;
  wire tdi = pin_s2_q.tdi;
  wire fifo_rdy;
  // A full output queue drops the one-cycle edge pulse, so the state does not move on it
  wire step = rise_ev && fifo_rdy;

  // ****************************************************************
  // Controller state machine
  // ****************************************************************
  bst_pkg::bst_state_t state_q, state_d;

  // Next state from mode-select, split into data and instruction arms
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      bst_pkg::ST_TLR: state_d = tms ? bst_pkg::ST_TLR : bst_pkg::ST_RTI;
      bst_pkg::ST_RTI: state_d = tms ? bst_pkg::ST_SDR : bst_pkg::ST_RTI;
      bst_pkg::ST_SDR: state_d = tms ? bst_pkg::ST_SIR : bst_pkg::ST_CDR;
      bst_pkg::ST_CDR: state_d = tms ? bst_pkg::ST_E1DR : bst_pkg::ST_SHDR;
      bst_pkg::ST_SHDR: state_d = tms ? bst_pkg::ST_E1DR : bst_pkg::ST_SHDR;
      bst_pkg::ST_E1DR: state_d = tms ? bst_pkg::ST_UDR : bst_pkg::ST_PDR;
      bst_pkg::ST_PDR: state_d = tms ? bst_pkg::ST_E2DR : bst_pkg::ST_PDR;
      bst_pkg::ST_E2DR: state_d = tms ? bst_pkg::ST_UDR : bst_pkg::ST_SHDR;
      bst_pkg::ST_UDR: state_d = tms ? bst_pkg::ST_SDR : bst_pkg::ST_RTI;
      bst_pkg::ST_SIR: state_d = tms ? bst_pkg::ST_TLR : bst_pkg::ST_CIR;
      bst_pkg::ST_CIR: state_d = tms ? bst_pkg::ST_E1IR : bst_pkg::ST_SHIR;
      bst_pkg::ST_SHIR: state_d = tms ? bst_pkg::ST_E1IR : bst_pkg::ST_SHIR;
      bst_pkg::ST_E1IR: state_d = tms ? bst_pkg::ST_UIR : bst_pkg::ST_PIR;
      bst_pkg::ST_PIR: state_d = tms ? bst_pkg::ST_E2IR : bst_pkg::ST_PIR;
      bst_pkg::ST_E2IR: state_d = tms ? bst_pkg::ST_UIR : bst_pkg::ST_SHIR;
      bst_pkg::ST_UIR: state_d = tms ? bst_pkg::ST_SDR : bst_pkg::ST_RTI;
    endcase
  end

  // State moves only on an accepted rising test clock edge
  always_ff @(posedge clk) begin
    if (rst) state_q <= bst_pkg::ST_TLR;
    else if (clk_en && step) state_q <= state_d;
  end

  wire in_cdr = (state_q == bst_pkg::ST_CDR);
  wire in_shdr = (state_q == bst_pkg::ST_SHDR);
  wire in_udr = (state_q == bst_pkg::ST_UDR);
  wire in_cir = (state_q == bst_pkg::ST_CIR);
  wire in_shir = (state_q == bst_pkg::ST_SHIR);
  wire in_uir = (state_q == bst_pkg::ST_UIR);
  wire in_shift = in_shdr || in_shir;

  // ****************************************************************
  // Instruction register and decode
  // ****************************************************************
  logic [IL-1:0] ir_sh_q, ir_q;

  // Capture, shift, then update into the active instruction
  always_ff @(posedge clk) begin
    if (rst) begin
      ir_sh_q <= bst_pkg::IR_CAPTURE;
      ir_q <= bst_pkg::OP_IDCODE;
    end else if (clk_en && step) begin
      if (in_cir) ir_sh_q <= bst_pkg::IR_CAPTURE;
      if (in_shir) ir_sh_q <= {tdi, ir_sh_q[IL-1:1]};
      if (state_d == bst_pkg::ST_TLR) ir_q <= bst_pkg::OP_IDCODE;
      else if (in_uir) ir_q <= ir_sh_q;
    end
  end

  // Opcode decode; unknown codes fall back to bypass
  wire op_extest = (ir_q == bst_pkg::OP_EXTEST);
  wire op_sample = (ir_q == bst_pkg::OP_SAMPLE);
  wire op_clamp = (ir_q == bst_pkg::OP_CLAMP);
  wire op_highz = (ir_q == bst_pkg::OP_HIGHZ);
  wire sel_id = (ir_q == bst_pkg::OP_IDCODE);
  wire sel_bsc = op_extest || op_sample;
  wire sel_pass = !sel_id && !sel_bsc;
  wire drive_test = op_extest || op_clamp;

  // ****************************************************************
  // Data registers
  // ****************************************************************
  logic single_bit_passthrough_q;
  logic [bst_pkg::ID_LEN-1:0] device_identity_shift_reg_q;
  logic [CL-1:0] boundary_scan_chain_q, chain_upd_q;
  logic [CL-1:0] chain_cap;

  // Identity word with its fixed bit in the lsb
  wire [bst_pkg::ID_LEN-1:0] id_word = {bst_pkg::ID_VERSION,
    bst_pkg::ID_PART, bst_pkg::ID_MFR, bst_pkg::ID_FIXED};

  // Cell 2i is the observe-only in cell, 2i+1 the out cell
  for (genvar i = 0; i < N_PINS; i++) begin : g_cap
    assign chain_cap[2*i] = pad_s2_q[i];
    assign chain_cap[2*i+1] = drive_test ? chain_upd_q[2*i+1]
                                         : core_out[i];
  end

  // Bypass path, one bit only
  always_ff @(posedge clk) begin
    if (rst) single_bit_passthrough_q <= bst_pkg::PASS_CAPTURE;
    else if (clk_en && step && sel_pass) begin
      if (in_cdr) single_bit_passthrough_q <= bst_pkg::PASS_CAPTURE;
      if (in_shdr) single_bit_passthrough_q <= tdi;
    end
  end

  // Identity path loads the word, then shifts it out lsb first
  always_ff @(posedge clk) begin
    if (rst) device_identity_shift_reg_q <= id_word;
    else if (clk_en && step && sel_id) begin
      if (in_cdr) device_identity_shift_reg_q <= id_word;
      if (in_shdr) device_identity_shift_reg_q <=
        {tdi, device_identity_shift_reg_q[bst_pkg::ID_LEN-1:1]};
    end
  end

  // Scan chain; update stage keeps pins steady while shifting
  always_ff @(posedge clk) begin
    if (rst) begin
      boundary_scan_chain_q <= '0;
      chain_upd_q <= '0;
    end else if (clk_en && step && sel_bsc) begin
      if (in_cdr) boundary_scan_chain_q <= chain_cap;
      if (in_shdr) boundary_scan_chain_q <=
        {tdi, boundary_scan_chain_q[CL-1:1]};
      if (in_udr) chain_upd_q <= boundary_scan_chain_q;
    end
  end

  // ****************************************************************
  // Serial output queue and data-out pin
  // ****************************************************************
  logic push_q;
  logic fifo_ov;
  logic [0:0] fifo_od;
  logic tdo_q, tdo_oe_q;

  // Bit that the next falling edge must present
  wire ser_bit = in_shir ? ir_sh_q[0]
               : sel_id ? device_identity_shift_reg_q[0]
               : sel_bsc ? boundary_scan_chain_q[0]
               : single_bit_passthrough_q;
  wire push = push_q && in_shift;

  // Queue the output bit one cycle after the state has moved
  always_ff @(posedge clk) begin
    if (rst) push_q <= 1'h0;
    else if (clk_en) push_q <= step;
  end

  bst_fifo #(
    .W(1),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst(rst),
    .clk_en(clk_en),
    .in_valid(push),
    .in_ready(fifo_rdy),
    .in_data(ser_bit),
    .out_valid(fifo_ov),
    .out_ready(fall_ev),
    .out_data(fifo_od)
  );

  // Data-out and its enable move only on a falling test clock edge
  always_ff @(posedge clk) begin
    if (rst) begin
      tdo_q <= 1'h0;
      tdo_oe_q <= 1'h0;
    end else if (clk_en && fall_ev) begin
      tdo_oe_q <= in_shift;
      if (fifo_ov) tdo_q <= fifo_od[0];
    end
  end

  assign tdo = tdo_q;
  assign tdo_oe = tdo_oe_q;

  // ****************************************************************
  // Pin drive muxes
  // ****************************************************************
  logic [N_PINS-1:0] pad_out_q, pad_oe_q, pad_out_d, pad_oe_d;

  // Test modes take the pins from the update stage; highz floats all
  for (genvar i = 0; i < N_PINS; i++) begin : g_pad
    assign pad_out_d[i] = drive_test ? chain_upd_q[2*i+1] : core_out[i];
    assign pad_oe_d[i] = op_highz ? 1'h0
                       : drive_test ? 1'h1 : core_oe[i];
  end

  // Registered so every pin changes on a clean clock edge
  always_ff @(posedge clk) begin
    if (rst) begin
      pad_out_q <= '0;
      pad_oe_q <= '0;
    end else if (clk_en) begin
      pad_out_q <= pad_out_d;
      pad_oe_q <= pad_oe_d;
    end
  end

  assign pad_out = pad_out_q;
  assign pad_oe = pad_oe_q;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  // Counts accepted edges with mode-select high, saturating
  logic [2:0] tms_run_q;
  always_ff @(posedge clk) begin
    if (rst) tms_run_q <= 3'h0;
    else if (clk_en && step) begin
      if (!tms) tms_run_q <= 3'h0;
      else if (tms_run_q != RUN_MAX) tms_run_q <= tms_run_q + 3'h1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_cap_dr;
    clk_en && step && in_cdr;
  endsequence
  sequence s_upd_ir;
    clk_en && step && in_uir;
  endsequence
  sequence s_sh_dr;
    clk_en && step && in_shdr;
  endsequence

  five_tms_a: assert property (
    tms_run_q == RUN_MAX |-> state_q == bst_pkg::ST_TLR)
    else $error("five high mode edges did not reach reset state");

  reset_idcode_a: assert property (
    state_q == bst_pkg::ST_TLR |-> ir_q == bst_pkg::OP_IDCODE)
    else $error("reset state without idcode instruction");

  state_step_a: assert property (
    !(clk_en && step) |=> $stable(state_q))
    else $error("state moved without a rising test clock edge");

  dr_ir_branch_a: assert property (
    clk_en && step && state_q == bst_pkg::ST_SDR && tms
    |=> state_q == bst_pkg::ST_SIR)
    else $error("select-dr did not branch to select-ir");

  ir_update_a: assert property (
    s_upd_ir ##1 !(state_q == bst_pkg::ST_TLR)
    |-> ir_q == $past(ir_sh_q))
    else $error("instruction not taken at update");

  pass_capture_a: assert property (
    s_cap_dr ##0 sel_pass |=> single_bit_passthrough_q == 1'h0)
    else $error("bypass bit not cleared at capture");

  id_fixed_a: assert property (
    s_cap_dr ##0 sel_id |=> device_identity_shift_reg_q[0] == 1'h1)
    else $error("identity fixed bit missing after capture");

  tdo_edge_a: assert property (
    !(clk_en && fall_ev) |=> $stable(tdo_oe_q) && $stable(tdo_q))
    else $error("data-out changed away from a falling edge");

  tdo_float_a: assert property (
    clk_en && fall_ev && !in_shift |=> !tdo_oe_q)
    else $error("data-out driven outside shift states");

  highz_pins_a: assert property (
    clk_en && op_highz ##1 clk_en && op_highz |-> pad_oe_q == '0)
    else $error("pins driven under highz");

  shift_id_a: assert property (
    s_sh_dr ##0 sel_id
    |=> device_identity_shift_reg_q[bst_pkg::ID_LEN-1] == $past(tdi))
    else $error("identity shift lost the data-in bit");

  pass_shift_a: assert property (
    s_sh_dr ##0 sel_pass |=> single_bit_passthrough_q == $past(tdi))
    else $error("bypass bit did not follow data-in");

  chain_cap_a: assert property (
    s_cap_dr ##0 sel_bsc
    |=> boundary_scan_chain_q[0] == $past(pad_s2_q[0]))
    else $error("in cell did not observe its pin");

  ir_capture_a: assert property (
    clk_en && step && in_cir |=> ir_sh_q == bst_pkg::IR_CAPTURE)
    else $error("instruction capture pattern missing");

  tdo_drive_a: assert property (
    clk_en && fall_ev && in_shift |=> tdo_oe_q)
    else $error("data-out not driven in a shift state");

  test_drive_a: assert property (
    clk_en && drive_test ##1 clk_en && drive_test |-> pad_oe_q == '1)
    else $error("pins not driven under extest or clamp");

endmodule : bst_tap

// ===== bst_ctl_model.sv
// Test controller model that drives the three test pins
`timescale 1ns/1ps
module bst_ctl_model (
  input wire logic clk, // System clock
  output bst_pkg::bst_pins_t pins, // Test clock, mode, data-in
  input wire logic tdo, // Test data out
  input wire logic tdo_oe // Data-out drive enable
);
  // ****************************************************************
  // Pin sequencing
  // ****************************************************************
  localparam int HALF = 20; // 80 ns half period at 4 ns per clk

  initial pins = '0;

  // Idle data line toggles at random, so a stale level never passes
  function automatic logic rb();
    return 1'($urandom);
  endfunction : rb

  // Mode and data change while the clock is low and hold past the rise
  task automatic step(input logic m, input logic d, output logic so,
                      output logic soe);
    pins.tms <= m;
    pins.tdi <= d;
    repeat (HALF) @(posedge clk);
    so = tdo_oe ? tdo : !tdo; // Undriven line reads inverted, never stale
    soe = tdo_oe;
    pins.tck <= 1'b1;
    repeat (HALF) @(posedge clk);
    pins.tck <= 1'b0; // Clock rests low between frames
  endtask : step

  // One scan from Run-Test/Idle through either branch and back again
  task automatic scan(input logic ir, input int n, input int pz,
                      input logic [63:0] din, output logic [63:0] dout,
                      output logic oe_bad);
    logic so;
    logic soe;
    dout = '0;
    step(1'b1, rb(), so, soe);
    if (ir) begin
      step(1'b1, rb(), so, soe);
    end
    step(1'b0, rb(), so, soe);
    step(1'b0, rb(), so, soe);
    oe_bad = (soe !== 1'b0);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1 || i == pz, din[i], so, soe);
      dout[i] = so;
      if (soe !== 1'b1) oe_bad = 1'b1;
      // Detour through the pause states after bit pz, then resume
      if (i == pz && i != n - 1) begin
        step(1'b0, rb(), so, soe);
        step(1'b0, rb(), so, soe);
        if (soe !== 1'b0) oe_bad = 1'b1;
        step(1'b1, rb(), so, soe);
        step(1'b0, rb(), so, soe);
      end
    end
    step(1'b1, rb(), so, soe);
    if (soe !== 1'b0) oe_bad = 1'b1;
    step(1'b0, rb(), so, soe);
  endtask : scan
endmodule : bst_ctl_model

// ===== bst_tap_tb.sv
// Self-checking bench for the boundary-scan test port
`timescale 1ns/1ps
module bst_tap_tb;
  localparam int NP = 16;
  localparam int DRL = 2 * NP + 1; // One bit past the longest path
  logic clk;
  logic rst;
  logic clk_en;
  bst_pkg::bst_pins_t pins;
  logic tdo;
  logic tdo_oe;
  logic [NP-1:0] core_out;
  logic [NP-1:0] core_oe;
  logic [NP-1:0] pad_in;
  logic [NP-1:0] pad_out;
  logic [NP-1:0] pad_oe;
  logic [NP-1:0] upd;
  int errors;
  int num_checks;

  // ****************************************************************
  // Clock, design and controller
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  bst_tap #(.N_PINS(NP), .FIFO_DEPTH(8)) dut (.clk(clk), .rst(rst),
    .clk_en(clk_en), .jtag_i(pins), .tdo(tdo), .tdo_oe(tdo_oe),
    .core_out(core_out), .core_oe(core_oe), .pad_in(pad_in),
    .pad_out(pad_out), .pad_oe(pad_oe));

  bst_ctl_model ctl (.clk(clk), .pins(pins), .tdo(tdo), .tdo_oe(tdo_oe));

  // ****************************************************************
  // Checking helpers
  // ****************************************************************
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic final_report();
    if (errors == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : final_report

  function automatic logic chain_op(input logic [3:0] op);
    return op == bst_pkg::OP_SAMPLE || op == bst_pkg::OP_EXTEST;
  endfunction : chain_op

  // Bits seen at data-out when DRL bits are shifted with op loaded
  function automatic logic [63:0] exp_dr(input logic [3:0] op,
                                         input logic [63:0] d);
    logic [63:0] c;
    c = {d[62:0], bst_pkg::PASS_CAPTURE};
    if (op == bst_pkg::OP_IDCODE) begin
      c = '0;
      c[31:0] = {bst_pkg::ID_VERSION, bst_pkg::ID_PART, bst_pkg::ID_MFR,
                 bst_pkg::ID_FIXED};
      c[bst_pkg::ID_LEN] = d[0];
    end
    if (chain_op(op)) begin
      c = '0;
      for (int i = 0; i < NP; i++) begin
        c[2*i] = pad_in[i];
        c[2*i+1] = (op == bst_pkg::OP_EXTEST) ? upd[i] : core_out[i];
      end
      c[2*NP] = d[0];
    end
    return c & ((64'h1 << DRL) - 64'h1);
  endfunction : exp_dr

  // Pin outputs expected for the loaded instruction
  task automatic chk_pads(input logic [3:0] op);
    logic frc;
    frc = op == bst_pkg::OP_EXTEST || op == bst_pkg::OP_CLAMP;
    chk(64'(pad_out), 64'(frc ? upd : core_out));
    chk(64'(pad_oe), 64'(frc ? {NP{1'b1}} :
        (op == bst_pkg::OP_HIGHZ ? {NP{1'b0}} : core_oe)));
  endtask : chk_pads

  // Random data scan through the data branch, checked against op
  task automatic dr_scan(input logic [3:0] op);
    logic [63:0] d;
    logic [63:0] q;
    logic bad;
    d = {$urandom, $urandom};
    ctl.scan(1'b0, DRL, int'($urandom % DRL), d, q, bad);
    chk(q, exp_dr(op, d));
    chk(64'(bad), 64'h0);
    if (chain_op(op)) begin
      for (int i = 0; i < NP; i++) upd[i] = d[2*i+2];
    end
  endtask : dr_scan

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    logic [3:0] ops [7];
    logic [63:0] q;
    logic bad;
    logic so;
    logic soe;
    ops = '{bst_pkg::OP_SAMPLE, bst_pkg::OP_EXTEST, bst_pkg::OP_CLAMP,
            bst_pkg::OP_HIGHZ, bst_pkg::OP_IDCODE, 4'h7,
            bst_pkg::OP_BYPASS};
    errors = 0;
    num_checks = 0;
    rst = 1'b1;
    clk_en = 1'b1;
    core_out = '0;
    core_oe = '0;
    pad_in = '0;
    upd = '0;
    void'($urandom(32'h7A5C));
    repeat (12) @(posedge clk);
    chk(64'({tdo_oe, pad_oe}), 64'h0);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    ctl.step(1'b0, 1'b0, so, soe);
    dr_scan(bst_pkg::OP_IDCODE);
    // Every instruction with fresh random pin and core values
    for (int k = 0; k < 7; k++) begin
      core_out <= NP'($urandom);
      core_oe <= NP'($urandom);
      pad_in <= NP'($urandom);
      repeat (4) @(posedge clk);
      ctl.scan(1'b1, bst_pkg::IR_LEN, 1, 64'(ops[k]), q, bad);
      chk(q, 64'(bst_pkg::IR_CAPTURE));
      chk(64'(bad), 64'h0);
      chk_pads(ops[k]);
      // Clock enable dropped briefly mid-scan; the scan must still pass
      fork
        dr_scan(ops[k]);
        begin
          repeat (100 + $urandom % 1000) @(posedge clk);
          clk_en <= 1'b0;
          repeat (1 + $urandom % 10) @(posedge clk);
          clk_en <= 1'b1;
        end
      join
      chk_pads(ops[k]);
    end
    // Mode-select held high from mid-shift returns to reset
    ctl.step(1'b1, 1'b0, so, soe);
    ctl.step(1'b0, 1'b0, so, soe);
    ctl.step(1'b0, 1'b0, so, soe);
    ctl.step(1'b0, 1'b1, so, soe);
    repeat (5) ctl.step(1'b1, 1'b0, so, soe);
    ctl.step(1'b0, 1'b0, so, soe);
    chk(64'(soe), 64'h0);
    dr_scan(bst_pkg::OP_IDCODE);
    // Second system reset while pins are forced by extest
    ctl.scan(1'b1, bst_pkg::IR_LEN, -1, 64'(bst_pkg::OP_EXTEST), q, bad);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    chk_pads(bst_pkg::OP_IDCODE);
    ctl.step(1'b0, 1'b0, so, soe);
    dr_scan(bst_pkg::OP_IDCODE);
    final_report();
  end

  // Watchdog well past the expected run of about 20000 cycles
  initial begin
    repeat (60000) @(posedge clk);
    errors++;
    final_report();
  end
endmodule : bst_tap_tb
